//--- dv/ppp_printer_model.sv
// Purpose: Printer on the far side of the parallel port
// Assumes: Bench takes over the status pins while cmd_en_in is high
// Notes:   Bench resolves the data wire from the port's output enable alone
`timescale 1ns/10ps
`default_nettype none
module ppp_printer_model (
    input  wire logic       clk_in,
    input  wire logic       strobe_n_in,
    input  wire logic [7:0] pins_in,
    input  wire logic       cmd_en_in,
    input  wire logic [4:0] cmd_in,
    input  wire logic [7:0] drv_in,
    output var  logic [7:0] drv_out,
    output var  logic [4:0] stat_out,
    output var  logic [7:0] cap_out,
    output var  int         width_out,
    output var  int         pulses_out
);
    int run = 0;
    int ack = 0;
    int wid = 0;
    int npl = 0;
    logic [7:0] cap = 8'h00;
    // Outputs come from one driver each; the counters start at zero
    assign cap_out    = cap;
    assign width_out  = wid;
    assign pulses_out = npl;
    assign drv_out    = drv_in;
    // Latch the byte as strobe falls, then answer with busy and ack
    always @(posedge clk_in) begin
        if (!strobe_n_in) begin
            if (run == 0) cap <= pins_in;
            run <= run + 1;
        end else if (run != 0) begin
            wid <= run;
            npl <= npl + 1;
            run <= 0;
            ack <= 3;
        end else if (ack != 0) begin
            ack <= ack - 1;
        end
    end
    // Order: ack_n, fault_n, occupied, select, media empty
    assign stat_out = cmd_en_in ? cmd_in :
        {1'b0, 1'b1, (run != 0 || ack != 0), 1'b1, (ack == 0)};
endmodule
`default_nettype wire

//--- dv/test_parallel_printer_port.sv
// Purpose: Self-checking bench of the parallel printer port
// Assumes: Short strobe times so each pulse lasts 20 or 8 cycles
// Notes:   Status pins handed to the bench for interrupt tests
`timescale 1ns/10ps
`default_nettype none
module test_parallel_printer_port;
    import ppp_pkg::*;
    localparam int unsigned SLOW = 100;
    localparam int unsigned FAST = 40;
    logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, cmd_en = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, drv = 8'h00, d;
    logic [31:0] wdata = 32'h0, rv;
    logic [4:0] cmd = 5'h00, m;
    logic [1:0] r;
    logic p0;
    wire logic awready, wready, bvalid, arready, rvalid, oe, stb_n;
    wire logic init_n, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] dout, pin, mdrv, cap;
    wire logic [4:0] st;
    int width, pulses, p, cyc = 0, n_fail = 0, compares = 0;
    assign pin = oe ? dout : mdrv;
    ppp_port #(.SLOW_NS(SLOW), .FAST_NS(FAST)) dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready), .DATA_IN(pin),
        .DATA_OUT(dout), .DATA_OE_OUT(oe), .ACK_N_IN(st[0]),
        .FAULT_N_IN(st[1]), .PRINTER_OCCUPIED_IN(st[2]),
        .SELECT_IN(st[3]), .MEDIA_EMPTY_IN(st[4]), .STROBE_N_OUT(stb_n),
        .PRINTER_INIT_PULSE_N_OUT(init_n), .IRQ_OUT(irq));
    ppp_printer_model prn (.clk_in(clk), .strobe_n_in(stb_n),
        .pins_in(pin), .cmd_en_in(cmd_en), .cmd_in(cmd), .drv_in(drv),
        .drv_out(mdrv), .stat_out(st), .cap_out(cap), .width_out(width),
        .pulses_out(pulses));
    initial forever #2.5 clk = ~clk;
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(logic [31:0] s, logic [31:0] e, string t);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s: %h vs %h", $time, t, s, e);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rv = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wrk(logic [7:0] a, logic [31:0] v);
        wr(a, v);
        chk(32'(r), 32'(RESP_OKAY), "bresp");
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] e, string t);
        rd(a);
        chk(rv, e, t);
    endtask
    function automatic logic [31:0] exp_len(int f);
        return 32'((f != 0 ? FAST : SLOW) * CLK_MHZ / 1000);
    endfunction
    initial begin
        void'($urandom(32'h1713));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rchk(OFF_CTRL, 32'h0, "ctrl rst");
        rchk(OFF_MODE, 32'h0, "mode rst");
        rchk(OFF_IMASK, 32'h0, "mask rst");
        chk(32'({stb_n, init_n, oe, irq}), 32'hc, "pins rst");
        wr(8'h20, 32'h1);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped wr");
        rd(8'h1c);
        chk({r, rv[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped rd");
        d = 8'($urandom);
        wrk(OFF_CTRL, 32'h1);
        wrk(OFF_DATA, {24'h0, d});
        repeat (2) @(posedge clk);
        chk(32'({oe, dout}), {23'h0, 1'b1, d}, "drive");
        rchk(OFF_DATA, {24'h0, d}, "data back");
        drv <= 8'($urandom);
        wrk(OFF_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        rchk(OFF_DATA, {24'h0, drv}, "data in");
        chk(32'(oe), 32'h0, "released");
        p = pulses;
        wrk(OFF_CTRL, 32'h19);
        wrk(OFF_DATA, 32'h5a);
        repeat (30) @(posedge clk);
        chk({stb_n, init_n, 30'(pulses - p)}, 32'h0, "manual on");
        wrk(OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'({stb_n, init_n}), 32'h3, "manual off");
        for (int f = 0; f < 2; f++) begin
            p = pulses;
            d = 8'($urandom);
            wrk(OFF_CTRL, 32'(3 + 4 * f));
            wrk(OFF_DATA, {24'h0, d});
            wrk(OFF_DATA, {24'h0, ~d});
            repeat (SLOW) @(posedge clk);
            chk(32'(pulses - p), 32'h1, "one pulse");
            chk(32'(width), exp_len(f), "width");
            chk({24'h0, cap, dout}, {24'h0, d, ~d}, "data");
        end
        cmd <= 5'h00;
        cmd_en <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < NSTAT; i++) begin
                p0 = (c == 1 || c == 2);
                m = 5'(1 << i);
                cmd <= {5{p0}};
                wrk(OFF_MODE, {22'h0, {5{2'(c)}}});
                wrk(OFF_IMASK, (c % 2 == 1) ? 32'(m) : 32'h0);
                repeat (6) @(posedge clk);
                rd(OFF_ISTAT);
                rchk(OFF_ISTAT, 32'h0, "idle");
                cmd <= {5{p0}} ^ m;
                repeat (6) @(posedge clk);
                chk(32'(irq), 32'(c % 2), "irq");
                rchk(OFF_ISTAT, 32'(m), "event");
                rchk(OFF_PINS, 32'({5{p0}} ^ m), "pins");
                rchk(OFF_ISTAT, c < 2 ? 32'(m) : 32'h0, "hold");
                cmd <= {5{p0}};
                repeat (6) @(posedge clk);
                rd(OFF_ISTAT);
                rchk(OFF_ISTAT, 32'h0, "gone");
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- hw/ppp_pkg.sv
// Purpose: Shared constants and types of the parallel printer port
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz core clock
// Notes:   Offsets are byte addresses of aligned words
package ppp_pkg;
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned STB_SLOW_NS  = 1000;
    localparam int unsigned STB_FAST_NS  = 250;
    localparam int unsigned ADDR_W       = 8;

    localparam logic [7:0] OFF_DATA      = 8'h00;
    localparam logic [7:0] OFF_CTRL      = 8'h04;
    localparam logic [7:0] OFF_PINS      = 8'h08;
    localparam logic [7:0] OFF_MODE      = 8'h0c;
    localparam logic [7:0] OFF_ISTAT     = 8'h10;
    localparam logic [7:0] OFF_IMASK     = 8'h14;

    localparam int unsigned CTL_DIR      = 0;
    localparam int unsigned CTL_AUTO     = 1;
    localparam int unsigned CTL_FAST     = 2;
    localparam int unsigned CTL_MSTB     = 3;
    localparam int unsigned CTL_INIT     = 4;
    localparam int unsigned CTL_W        = 5;
    localparam int unsigned PIN_BUSY     = 5;
    localparam int unsigned NSTAT        = 5;

    localparam logic [4:0] CTRL_RST      = 5'h00;
    localparam logic [9:0] MODE_RST      = 10'h000;
    localparam logic [4:0] MASK_RST      = 5'h00;
    localparam logic [7:0] DATA_RST      = 8'h00;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Interrupt condition per status input
    typedef enum logic [1:0] {
        PPP_HIGH = 2'h0,
        PPP_LOW  = 2'h1,
        PPP_FALL = 2'h2,
        PPP_RISE = 2'h3
    } ppp_cond_t;
endpackage

//--- hw/ppp_port.sv
// Purpose: Parallel printer / general parallel I/O port, AXI4-Lite slave
// Assumes: Pins are asynchronous and pass two flops; one clock domain
// Notes:   Status order 0 ack_n, 1 fault_n, 2 occupied, 3 select, 4 empty
//
// Behaviour
// RQ1 - One 8-bit data port, input or output
// RQ2 - One direction bit for all data pins
// RQ3 - Two control outputs, five status inputs
// RQ4 - Printer pin roles: ack, fault, busy, strobe
// RQ5 - Printer port or general parallel I/O
// RQ6 - Each status input raises interrupt independently
// RQ7 - Per input: high, low, fall, rise
// RQ8 - Auto mode: data write pulses strobe low
// RQ9 - Fast bit selects one of two widths
// RQ10 - Manual mode: strobe pin follows control bit
// RQ11 - Edges latch; levels request while present
// RQ12 - No retrigger during pulse; ends on time
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ppp_port
    import ppp_pkg::*;
#(
    parameter int unsigned SLOW_NS = STB_SLOW_NS,
    parameter int unsigned FAST_NS = STB_FAST_NS
) (
    input  wire logic              CLK_IN,
    input  wire logic              RSTN_IN,
    input  wire logic              CE_IN,
    input  wire logic [ADDR_W-1:0] AWADDR_IN,
    input  wire logic              AWVALID_IN,
    output var  logic              AWREADY_OUT,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic [3:0]        WSTRB_IN,
    input  wire logic              WVALID_IN,
    output var  logic              WREADY_OUT,
    output var  logic [1:0]        BRESP_OUT,
    output var  logic              BVALID_OUT,
    input  wire logic              BREADY_IN,
    input  wire logic [ADDR_W-1:0] ARADDR_IN,
    input  wire logic              ARVALID_IN,
    output var  logic              ARREADY_OUT,
    output var  logic [31:0]       RDATA_OUT,
    output var  logic [1:0]        RRESP_OUT,
    output var  logic              RVALID_OUT,
    input  wire logic              RREADY_IN,
    input  wire logic [7:0]        DATA_IN,
    output var  logic [7:0]        DATA_OUT,
    output var  logic              DATA_OE_OUT,
    input  wire logic              ACK_N_IN,
    input  wire logic              FAULT_N_IN,
    input  wire logic              PRINTER_OCCUPIED_IN,
    input  wire logic              SELECT_IN,
    input  wire logic              MEDIA_EMPTY_IN,
    output var  logic              STROBE_N_OUT,
    output var  logic              PRINTER_INIT_PULSE_N_OUT,
    output var  logic              IRQ_OUT
);
    // Least times round up, never below one cycle
    localparam int unsigned SLOW_C = (SLOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FAST_C = (FAST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] SLOW_LEN = 16'((SLOW_C < 1) ? 1 : SLOW_C);
    localparam logic [15:0] FAST_LEN = 16'((FAST_C < 1) ? 1 : FAST_C);

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFF_DATA) || (a == OFF_CTRL) || (a == OFF_PINS) ||
                 (a == OFF_MODE) || (a == OFF_ISTAT) || (a == OFF_IMASK);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic hit(input logic [1:0] m, input logic cur,
                                 input logic prev);
        unique case (ppp_cond_t'(m))
            PPP_HIGH: hit = cur;
            PPP_LOW:  hit = !cur;
            PPP_FALL: hit = prev && !cur;
            PPP_RISE: hit = !prev && cur;
        endcase
    endfunction

    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q, rdata_q;
    logic [3:0]        wstrb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [7:0]        dout_q, din_s1_q, din_s2_q;
    logic [4:0]        st_s1_q, st_s2_q, st_s3_q;
    logic [CTL_W-1:0]  ctrl_q;
    logic [9:0]        mode_q;
    logic [4:0]        mask_q, istat_q, istat_d, ev;
    logic              pulse_q, strobe_n_q, oe_q, init_n_q, irq_q;
    logic [15:0]       cnt_q, len;
    logic              wr_go, rd_go, wr_data, start, clr_ist;
    logic [31:0]       rd_mux;

    assign wr_go   = !awready_q && !wready_q && !bvalid_q;
    assign rd_go   = ARVALID_IN && arready_q;
    assign wr_data = wr_go && (awaddr_q == OFF_DATA);
    assign start   = wr_data && ctrl_q[CTL_AUTO] && !pulse_q; // RQ8 RQ12
    assign len     = ctrl_q[CTL_FAST] ? FAST_LEN : SLOW_LEN;  // RQ9
    assign clr_ist = rd_go && (ARADDR_IN == OFF_ISTAT);

    // Write channel: address and data taken in either order
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else if (CE_IN) begin
            if (AWVALID_IN && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= AWADDR_IN;
            end
            if (WVALID_IN && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= WDATA_IN;
                wstrb_q  <= WSTRB_IN;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && BREADY_IN) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ARADDR_IN)
            OFF_DATA:  rd_mux[7:0] = ctrl_q[CTL_DIR] ? dout_q : din_s2_q;
            OFF_CTRL:  rd_mux[CTL_W-1:0] = ctrl_q;
            OFF_PINS:  rd_mux[PIN_BUSY:0] = {pulse_q, st_s2_q};
            OFF_MODE:  rd_mux[9:0] = mode_q;
            OFF_ISTAT: rd_mux[4:0] = istat_q;
            OFF_IMASK: rd_mux[4:0] = mask_q;
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // Read channel: one read at a time, answer one cycle after address
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (CE_IN) begin
            if (rd_go) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_mux;
                rresp_q   <= mapped(ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && RREADY_IN) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            dout_q <= DATA_RST;
            ctrl_q <= CTRL_RST;
            mode_q <= MODE_RST;
            mask_q <= MASK_RST;
        end else if (CE_IN && wr_go) begin
            unique case (awaddr_q)
                OFF_DATA:  dout_q <= 8'(merge({24'h0, dout_q}, wdata_q,
                                              wstrb_q));
                OFF_CTRL:  ctrl_q <= CTL_W'(merge({27'h0, ctrl_q}, wdata_q,
                                                  wstrb_q));
                OFF_MODE:  mode_q <= 10'(merge({22'h0, mode_q}, wdata_q,
                                               wstrb_q));
                OFF_IMASK: mask_q <= 5'(merge({27'h0, mask_q}, wdata_q,
                                              wstrb_q));
                default:   ;
            endcase
        end
    end

    // Pin synchronisers; third stage only for edge detection
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
            st_s1_q  <= '0;
            st_s2_q  <= '0;
            st_s3_q  <= '0;
        end else if (CE_IN) begin
            din_s1_q <= DATA_IN;
            din_s2_q <= din_s1_q;
            st_s1_q  <= {MEDIA_EMPTY_IN, SELECT_IN, PRINTER_OCCUPIED_IN,
                         FAULT_N_IN, ACK_N_IN}; // RQ3 RQ4
            st_s2_q  <= st_s1_q;
            st_s3_q  <= st_s2_q;
        end
    end

    always_comb begin
        for (int i = 0; i < NSTAT; i++) begin
            ev[i] = hit(mode_q[2*i +: 2], st_s2_q[i], st_s3_q[i]); // RQ6 RQ7
        end
        // A new event beats the clear of the same read
        istat_d = (istat_q & ~{5{clr_ist}}) | ev; // RQ11
    end

    // Sticky status; a level keeps setting its bit while present
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            istat_q <= '0;
            irq_q   <= 1'b0;
        end else if (CE_IN) begin
            istat_q <= istat_d;
            irq_q   <= |(istat_q & mask_q);
        end
    end

    // Strobe timer; writes during a pulse update data but do not restart
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pulse_q <= 1'b0;
            cnt_q   <= '0;
        end else if (CE_IN) begin
            if (start) begin
                pulse_q <= 1'b1;
                cnt_q   <= '0;
            end else if (pulse_q) begin
                if (cnt_q >= len - 16'h0001) begin
                    pulse_q <= 1'b0; // RQ12
                end else begin
                    cnt_q <= cnt_q + 16'h0001; // RQ9
                end
            end
        end
    end

    // Pin drivers
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            strobe_n_q <= 1'b1;
            oe_q       <= 1'b0;
            init_n_q   <= 1'b1;
        end else if (CE_IN) begin
            strobe_n_q <= ctrl_q[CTL_AUTO] ? !pulse_q
                                           : !ctrl_q[CTL_MSTB]; // RQ8 RQ10
            oe_q       <= ctrl_q[CTL_DIR]; // RQ1 RQ2 RQ5
            init_n_q   <= !ctrl_q[CTL_INIT]; // RQ4
        end
    end

    assign AWREADY_OUT = awready_q;
    assign WREADY_OUT  = wready_q;
    assign BVALID_OUT  = bvalid_q;
    assign BRESP_OUT   = bresp_q;
    assign ARREADY_OUT = arready_q;
    assign RVALID_OUT  = rvalid_q;
    assign RDATA_OUT   = rdata_q;
    assign RRESP_OUT   = rresp_q;
    assign DATA_OUT    = dout_q;
    assign DATA_OE_OUT = oe_q;
    assign STROBE_N_OUT = strobe_n_q;
    assign PRINTER_INIT_PULSE_N_OUT = init_n_q;
    assign IRQ_OUT     = irq_q;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN || !CE_IN);

    sequence s_auto_write;
        wr_data && ctrl_q[CTL_AUTO] && !pulse_q;
    endsequence
    sequence s_strobe_low;
        pulse_q ##1 !STROBE_N_OUT;
    endsequence

    AST_AUTO_STROBE: assert property ( // RQ8
        s_auto_write |=> s_strobe_low)
        else $error("auto write gave no strobe");
    AST_PULSE_LEN: assert property ( // RQ9
        $fell(pulse_q) |-> $past(cnt_q) == $past(len) - 16'h0001)
        else $error("strobe width wrong");
    AST_NO_RETRIG: assert property ( // RQ12
        (pulse_q && wr_data && cnt_q < len - 16'h0001)
        |=> pulse_q && cnt_q == $past(cnt_q) + 16'h0001)
        else $error("strobe restarted");
    AST_MANUAL: assert property ( // RQ10
        !ctrl_q[CTL_AUTO] ##1 !ctrl_q[CTL_AUTO]
        |-> STROBE_N_OUT == !$past(ctrl_q[CTL_MSTB]))
        else $error("manual strobe mismatch");
    AST_DIR_ALL: assert property ( // RQ2
        $changed(ctrl_q[CTL_DIR]) |=> DATA_OE_OUT == $past(ctrl_q[CTL_DIR]))
        else $error("data direction not applied");
    AST_EVENT_LATCH: assert property ( // RQ11
        (ev != 5'h00) |=> (istat_q & $past(ev)) == $past(ev))
        else $error("event lost");
    AST_LEVEL_HOLD: assert property ( // RQ7
        (mode_q[1:0] == 2'h0 && st_s2_q[0]) |=> istat_q[0])
        else $error("level request missing");
    AST_IRQ: assert property ( // RQ6
        ##1 IRQ_OUT == $past(|(istat_q & mask_q)))
        else $error("irq output mismatch");
    AST_UNMAPPED: assert property (
        (rd_go && !mapped(ARADDR_IN)) |=> RVALID_OUT &&
        RRESP_OUT == RESP_SLVERR)
        else $error("unmapped read not refused");
    AST_B_HOLD: assert property (
        BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
        else $error("bvalid dropped");
endmodule
`default_nettype wire
